// ### rtl/secfe_cfg.svh
// constants of the serial memory command front end
`ifndef SECFE_CFG_SVH
`define SECFE_CFG_SVH

// ****************************************
// opcodes
// ****************************************
`define SECFE_OP_SET_LATCH    8'h06
`define SECFE_OP_CLEAR_LATCH  8'h04
`define SECFE_OP_STATUS_FETCH 8'h05
`define SECFE_OP_STATUS_WRITE 8'h01
`define SECFE_OP_ARRAY_READ   8'h03
`define SECFE_OP_ARRAY_WRITE  8'h02

// ****************************************
// array geometry and protected ranges
// ****************************************
`define SECFE_ADDR_W          11
`define SECFE_BASE_QUARTER    11'h600
`define SECFE_BASE_HALF       11'h400
`define SECFE_BASE_WHOLE      11'h000

// ****************************************
// status byte fields and byte counts
// ****************************************
`define SECFE_SR_LOCK         7
`define SECFE_SR_BP_HI        3
`define SECFE_SR_BP_LO        2
`define SECFE_SR_LATCH        1
`define SECFE_SR_BUSY         0
`define SECFE_BYTES_LATCH     8'h01
`define SECFE_BYTES_STATUS    8'h02
`define SECFE_BYTES_ADDR_END  8'h03
`define SECFE_BYTES_WRITE_MIN 8'h04
`define SECFE_BYTE_CNT_MAX    8'hff

`endif

// ### rtl/secfe_pkg.sv
// types of the serial memory command front end
package secfe_pkg;

    // ****************************************
    // interface state
    // ****************************************
    typedef enum logic [3:0] {
        ST_IDLE       = 4'h0,
        ST_OPCODE     = 4'h1,
        ST_SET_WAIT   = 4'h2,
        ST_CLR_WAIT   = 4'h3,
        ST_FETCH      = 4'h4,
        ST_STATUS_WR  = 4'h5,
        ST_READ_ADDR  = 4'h6,
        ST_READ_DATA  = 4'h7,
        ST_WRITE_ADDR = 4'h8,
        ST_WRITE_DATA = 4'h9,
        ST_IGNORE     = 4'ha
    } secfe_state_t;

    typedef struct packed {
        logic         sclk_p;
        logic         ncs_p;
        logic         hold_p;
        logic         sel;
        logic         paused;
        secfe_state_t st;
        logic [6:0]   shreg;
        logic [2:0]   bit_cnt;
        logic [7:0]   byte_cnt;
        logic [10:0]  addr;
        logic [10:0]  page_addr;
        logic         dout;
        logic         oe_n;
        logic         latch;
        logic         busy;
        logic         lock;
        logic [1:0]   bp;
        logic [2:0]   pend;
        logic         pend_st;
        logic         st_go;
        logic         wr_commit;
        logic         wr_valid;
        logic [7:0]   wr_byte;
        logic [10:0]  wr_addr;
        logic         rd_req;
    } secfe_core_t;

endpackage : secfe_pkg

// ### rtl/secfe_sync.sv
// two-stage synchroniser for the serial pins
`timescale 1ns/1ps
module secfe_sync #(
    parameter int W = 5
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         nrst,
    // pins in, synced out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } secfe_sync_t;

    secfe_sync_t s_q;
    secfe_sync_t s_d;

    always_comb begin
        s_d      = s_q;
        s_d.meta = pin_in;
        s_d.sync = s_q.meta;
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign pin_sync = s_q.sync;

endmodule : secfe_sync

// ### rtl/secfe_protect.sv
// block-protect decoder
`timescale 1ns/1ps
`include "secfe_cfg.svh"
module secfe_protect (
    // protect setting
    input  wire logic [1:0]                bp,
    // address under test
    input  wire logic [`SECFE_ADDR_W-1:0] addr,
    output logic                           prot
);
    always_comb begin
        unique case (bp)
            2'h0: prot = 1'b0;
            2'h1: prot = (addr >= `SECFE_BASE_QUARTER);
            2'h2: prot = (addr >= `SECFE_BASE_HALF);
            2'h3: prot = (addr >= `SECFE_BASE_WHOLE);
        endcase
    end

endmodule : secfe_protect

// ### rtl/secfe_core.sv
// command front end of a serial nonvolatile memory
// Summary of operation
// R1 - after reset stay unselected until chip select falls
// R2 - no instruction or write accepted during power-on reset
// R3 - reset leaves standby, deselected, unpaused, latch and busy cleared
// R4 - reset keeps lock and block-protect bits
// R5 - low chip select selects, high deselects; busy keeps write running
// R6 - master pauses only while chip select is low
// R7 - pause starts and ends on hold edges while serial clock low
// R8 - paused: output high impedance, clock and data ignored, count kept
// R9 - chip select rising while paused abandons the sequence
// R10 - writes execute only on a whole number of bytes
// R11 - data-changing instructions need the write latch set
// R12 - latch cleared by reset, clear command, write completion
// R13 - protect bits map to none, upper quarter, upper half, whole array
// R14 - write-protect pin guards the protect bits
// R15 - non-read instruction executes only when deselected at byte boundary
// R16 - set latch 06, clear latch 04, status fetch 05
// R17 - status write 01, array read 03, array write 02
// R18 - unknown opcode: ignore bus until next deselect and select
// R19 - only the set command sets the latch, after deselect
// R20 - clear command clears the latch on deselect
// R21 - latch commands act only when deselected exactly after one byte
// R22 - bits sampled on clock rise msb first, output changes on fall
// R23 - output high impedance while chip select high
// R24 - lock bit and write-protect low refuse status writes
`timescale 1ns/1ps
`include "secfe_cfg.svh"
module secfe_core (
    // clock and reset
    input  wire logic                      sys_clk,
    input  wire logic                      nrst,
    // serial pins
    input  wire logic                      spi_clk,
    input  wire logic                      ncs,
    input  wire logic                      din,
    input  wire logic                      nhold,
    input  wire logic                      nwp,
    output logic                           dout,
    output logic                           dout_oe_n,
    // nonvolatile status store
    input  wire logic                      nv_restore,
    input  wire logic [2:0]                nv_bits,
    output logic                           status_commit,
    output logic [2:0]                     status_new,
    // array write engine
    output logic                           wr_byte_valid,
    output logic [7:0]                     wr_byte,
    output logic [`SECFE_ADDR_W-1:0]      wr_byte_addr,
    output logic                           wr_commit,
    input  wire logic                      write_done,
    // array read port
    output logic [`SECFE_ADDR_W-1:0]      rd_addr,
    output logic                           rd_req,
    input  wire logic [7:0]                rd_data,
    // status view
    output logic                           write_latch_flag,
    output logic                           busy_flag,
    output logic                           status_lock_bit,
    output logic                           protect_size_hi,
    output logic                           protect_size_lo,
    output logic                           hardware_lock_mode,
    output logic                           selected,
    output logic                           paused
);
    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [4:0] pin_s;
    logic       sclk_s;
    logic       ncs_s;
    logic       din_s;
    logic       nhold_s;
    logic       nwp_s;

    secfe_sync #(.W(5)) u_sync (
        .sys_clk  (sys_clk),
        .nrst     (nrst),
        .pin_in   ({spi_clk, ncs, din, nhold, nwp}),
        .pin_sync (pin_s)
    );
    assign {sclk_s, ncs_s, din_s, nhold_s, nwp_s} = pin_s;

    // ****************************************
    // state and edges
    // ****************************************
    secfe_pkg::secfe_core_t s_q;
    secfe_pkg::secfe_core_t s_d;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       ncs_fall;
    logic       ncs_rise;
    logic       hold_fall;
    logic       hold_rise;
    logic       hw_lock;
    logic       page_prot;
    logic [7:0] full;
    logic [7:0] status_byte;

    assign sclk_rise = sclk_s & ~s_q.sclk_p;
    assign sclk_fall = ~sclk_s & s_q.sclk_p;
    assign ncs_fall  = s_q.ncs_p & ~ncs_s;                                  // [R1]
    assign ncs_rise  = ~s_q.ncs_p & ncs_s;
    assign hold_fall = s_q.hold_p & ~nhold_s;
    assign hold_rise = ~s_q.hold_p & nhold_s;
    assign hw_lock   = s_q.lock & ~nwp_s;                                   // [R24] [R14]
    assign full      = {s_q.shreg, din_s};                                  // [R22]

    always_comb begin
        status_byte                  = 8'h00;
        status_byte[`SECFE_SR_LOCK]  = s_q.lock;
        status_byte[`SECFE_SR_BP_HI] = s_q.bp[1];
        status_byte[`SECFE_SR_BP_LO] = s_q.bp[0];
        status_byte[`SECFE_SR_LATCH] = s_q.latch;
        status_byte[`SECFE_SR_BUSY]  = s_q.busy;
    end

    secfe_protect u_protect (
        .bp   (s_q.bp),
        .addr (s_q.page_addr),
        .prot (page_prot)                                                   // [R13]
    );

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        s_d           = s_q;
        s_d.st_go     = 1'b0;
        s_d.wr_commit = 1'b0;
        s_d.wr_valid  = 1'b0;
        s_d.rd_req    = 1'b0;
        s_d.sclk_p    = sclk_s;
        s_d.ncs_p     = ncs_s;
        s_d.hold_p    = nhold_s;
        if (nv_restore) begin
            {s_d.lock, s_d.bp} = nv_bits;
        end
        // completion of a self-timed write
        if (write_done) begin
            s_d.busy    = 1'b0;
            s_d.latch   = 1'b0;                                             // [R12]
            s_d.pend_st = 1'b0;
            if (s_q.pend_st) begin
                {s_d.lock, s_d.bp} = s_q.pend;
            end
        end
        if (ncs_fall) begin
            s_d.sel      = 1'b1;                                            // [R5]
            s_d.paused   = 1'b0;
            s_d.st       = secfe_pkg::ST_OPCODE;
            s_d.bit_cnt  = 3'h0;
            s_d.byte_cnt = 8'h00;
        end else if (ncs_rise) begin
            // execution only at a clean byte boundary, never from a pause
            if (s_q.sel && !s_q.paused && s_q.bit_cnt == 3'h0) begin      // [R15] [R10] [R9]
                unique case (s_q.st)
                    secfe_pkg::ST_SET_WAIT: begin
                        if (s_q.byte_cnt == `SECFE_BYTES_LATCH) begin
                            s_d.latch = 1'b1;                               // [R19] [R21]
                        end
                    end
                    secfe_pkg::ST_CLR_WAIT: begin
                        if (s_q.byte_cnt == `SECFE_BYTES_LATCH) begin
                            s_d.latch = 1'b0;                               // [R20] [R21]
                        end
                    end
                    secfe_pkg::ST_STATUS_WR: begin
                        if (s_q.byte_cnt == `SECFE_BYTES_STATUS && s_q.latch
                            && !s_q.busy && !hw_lock) begin                // [R11] [R24]
                            s_d.busy    = 1'b1;
                            s_d.pend_st = 1'b1;
                            s_d.st_go   = 1'b1;
                        end
                    end
                    secfe_pkg::ST_WRITE_DATA: begin
                        if (s_q.byte_cnt >= `SECFE_BYTES_WRITE_MIN && s_q.latch
                            && !s_q.busy && !page_prot) begin              // [R11] [R13]
                            s_d.busy      = 1'b1;
                            s_d.wr_commit = 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            s_d.sel      = 1'b0;                                            // [R5] [R9]
            s_d.paused   = 1'b0;
            s_d.st       = secfe_pkg::ST_IDLE;
            s_d.bit_cnt  = 3'h0;
            s_d.byte_cnt = 8'h00;
        end else if (s_q.sel) begin
            // pause entry and exit with the serial clock low
            if (hold_fall && !sclk_s) begin
                s_d.paused = 1'b1;                                          // [R7]
            end else if (hold_rise && !sclk_s) begin
                s_d.paused = 1'b0;                                          // [R7]
            end
            if (!s_q.paused && s_q.st != secfe_pkg::ST_IGNORE) begin      // [R8] [R18]
                if (sclk_rise) begin
                    s_d.shreg   = full[6:0];                                // [R22]
                    s_d.bit_cnt = s_q.bit_cnt + 3'h1;
                    if (s_q.bit_cnt == 3'h7) begin
                        if (s_q.byte_cnt != `SECFE_BYTE_CNT_MAX) begin
                            s_d.byte_cnt = s_q.byte_cnt + 8'h01;
                        end
                        unique case (s_q.st)
                            secfe_pkg::ST_OPCODE: begin
                                unique case (full)
                                    `SECFE_OP_SET_LATCH:                    // [R16]
                                        s_d.st = secfe_pkg::ST_SET_WAIT;
                                    `SECFE_OP_CLEAR_LATCH:                  // [R16]
                                        s_d.st = secfe_pkg::ST_CLR_WAIT;
                                    `SECFE_OP_STATUS_FETCH:                 // [R16]
                                        s_d.st = secfe_pkg::ST_FETCH;
                                    `SECFE_OP_STATUS_WRITE:                 // [R17]
                                        s_d.st = secfe_pkg::ST_STATUS_WR;
                                    `SECFE_OP_ARRAY_READ:                   // [R17]
                                        s_d.st = secfe_pkg::ST_READ_ADDR;
                                    `SECFE_OP_ARRAY_WRITE:                  // [R17]
                                        s_d.st = secfe_pkg::ST_WRITE_ADDR;
                                    default:
                                        s_d.st = secfe_pkg::ST_IGNORE;      // [R18]
                                endcase
                            end
                            secfe_pkg::ST_STATUS_WR: begin
                                if (s_q.byte_cnt == `SECFE_BYTES_LATCH) begin
                                    s_d.pend = {full[`SECFE_SR_LOCK],
                                                full[`SECFE_SR_BP_HI],
                                                full[`SECFE_SR_BP_LO]};
                                end
                            end
                            secfe_pkg::ST_READ_ADDR,
                            secfe_pkg::ST_WRITE_ADDR: begin
                                s_d.addr      = {s_q.addr[2:0], full};
                                s_d.page_addr = {s_q.addr[2:0], full};
                                if (s_q.byte_cnt == (`SECFE_BYTES_ADDR_END - 8'h01)) begin
                                    s_d.rd_req = (s_q.st == secfe_pkg::ST_READ_ADDR);
                                    s_d.st     = (s_q.st == secfe_pkg::ST_READ_ADDR)
                                               ? secfe_pkg::ST_READ_DATA
                                               : secfe_pkg::ST_WRITE_DATA;
                                end
                            end
                            secfe_pkg::ST_READ_DATA: begin
                                s_d.addr   = s_q.addr + 11'h001;
                                s_d.rd_req = 1'b1;
                            end
                            secfe_pkg::ST_WRITE_DATA: begin
                                s_d.wr_valid = 1'b1;
                                s_d.wr_byte  = full;
                                s_d.wr_addr  = s_q.addr;
                                s_d.addr     = s_q.addr + 11'h001;
                            end
                            default: begin
                            end
                        endcase
                    end
                end
                // output bits change after falling edges, msb first
                if (sclk_fall && (s_q.st == secfe_pkg::ST_FETCH
                                  || s_q.st == secfe_pkg::ST_READ_DATA)) begin
                    if (s_q.bit_cnt == 3'h0) begin
                        s_d.shreg = s_q.shreg;
                        s_d.dout  = (s_q.st == secfe_pkg::ST_FETCH)
                                  ? status_byte[7] : rd_data[7];            // [R22]
                        s_d.wr_byte = s_q.wr_byte;
                    end else begin
                        s_d.dout  = (s_q.st == secfe_pkg::ST_FETCH)
                                  ? status_byte[3'h7 - s_q.bit_cnt]
                                  : rd_data[3'h7 - s_q.bit_cnt];
                    end
                end
            end
        end
        s_d.oe_n = !(s_d.sel && !s_d.paused
                     && (s_d.st == secfe_pkg::ST_FETCH
                         || s_d.st == secfe_pkg::ST_READ_DATA));           // [R8] [R23]
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            s_q      <= '0;                                                 // [R2] [R3]
            s_q.oe_n <= 1'b1;
            s_q.lock <= nv_restore ? nv_bits[2] : s_q.lock;                // [R4]
            s_q.bp   <= nv_restore ? nv_bits[1:0] : s_q.bp;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign dout               = s_q.dout;
    assign dout_oe_n          = s_q.oe_n;
    assign status_commit      = s_q.st_go;
    assign status_new         = s_q.pend;
    assign wr_byte_valid      = s_q.wr_valid;
    assign wr_byte            = s_q.wr_byte;
    assign wr_byte_addr       = s_q.wr_addr;
    assign wr_commit          = s_q.wr_commit;
    assign rd_addr            = s_q.addr;
    assign rd_req             = s_q.rd_req;
    assign write_latch_flag   = s_q.latch;
    assign busy_flag          = s_q.busy;
    assign status_lock_bit    = s_q.lock;
    assign protect_size_hi    = s_q.bp[1];
    assign protect_size_lo    = s_q.bp[0];
    assign hardware_lock_mode = hw_lock;
    assign selected           = s_q.sel;
    assign paused             = s_q.paused;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    chk_por_state: assert property (!$past(nrst) |-> !s_q.sel && !s_q.latch // [R3]
        && !s_q.busy && !s_q.paused && s_q.oe_n)
        else $error("state after reset not clean");
    chk_nv_kept: assert property (!$past(nrst) && !$past(nv_restore)       // [R4]
        |-> s_q.bp == $past(s_q.bp) && s_q.lock == $past(s_q.lock))
        else $error("protect bits changed by reset");
    chk_select_edge: assert property ($rose(s_q.sel)                       // [R1]
        |-> $past(s_q.ncs_p) && !$past(ncs_s))
        else $error("selected without chip select fall");
    chk_hiz_desel: assert property (ncs_s && $past(ncs_s) |=> s_q.oe_n)    // [R23]
        else $error("output driven while deselected");
    chk_pause_freeze: assert property (s_q.paused && $past(s_q.paused)     // [R8]
        |-> $stable(s_q.bit_cnt) && s_q.oe_n)
        else $error("activity while paused");
    chk_latch_set: assert property ($rose(s_q.latch)                       // [R19]
        |-> $past(s_q.st) == secfe_pkg::ST_SET_WAIT && $past(ncs_rise)
            && $past(s_q.byte_cnt) == 8'h01 && $past(s_q.bit_cnt) == 3'h0)
        else $error("latch set by other path");
    chk_latch_clear: assert property ($fell(s_q.latch)                     // [R12]
        |-> !$past(nrst) || $past(write_done) || ($past(s_q.st) == secfe_pkg::ST_CLR_WAIT
            && $past(ncs_rise)))
        else $error("latch cleared by other path");
    chk_write_gate: assert property (s_q.wr_commit                         // [R10]
        |-> $past(s_q.bit_cnt) == 3'h0 && $past(s_q.latch)
            && !$past(page_prot) && $past(s_q.byte_cnt) >= 8'h04)
        else $error("array write accepted wrongly");
    chk_status_gate: assert property (s_q.st_go                            // [R24]
        |-> !$past(hw_lock) && $past(s_q.latch) && $past(s_q.byte_cnt) == 8'h02)
        else $error("status write accepted wrongly");
    chk_ignore_hold: assert property (s_q.st == secfe_pkg::ST_IGNORE       // [R18]
        && !ncs_rise |=> s_q.st == secfe_pkg::ST_IGNORE)
        else $error("left ignore without deselect");
    chk_busy_start: assert property ((s_q.wr_commit || s_q.st_go)          // [R5]
        |-> s_q.busy [*2])
        else $error("busy not held after write start");

    cov_latch_set: cover property ($rose(s_q.latch));
    cov_status_write: cover property (s_q.st_go ##[1:1000] !s_q.busy);
    cov_pause: cover property ($rose(s_q.paused) ##[1:1000] $fell(s_q.paused));
    cov_bad_opcode: cover property (s_q.st == secfe_pkg::ST_IGNORE);

endmodule : secfe_core

// ### testbench/secfe_master.sv
// spi master model on the serial pins
`timescale 1ns/1ps
module secfe_master (
    // clock
    input  wire logic sys_clk,
    // serial pins
    output logic      spi_clk,
    output logic      ncs,
    output logic      din,
    output logic      nhold,
    input  wire logic dout,
    input  wire logic dout_oe_n,
    // bytes read back
    output logic [7:0] got
);
    logic [7:0] sh;
    initial begin
        got = 8'h00;
        sh = 8'h00;
        spi_clk = 1'b0;
        ncs = 1'b1;
        din = 1'b0;
        nhold = 1'b1;
    end
    task automatic wt(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : wt
    // n bits msb first, ncs up after last fall
    task automatic frame(input logic [31:0] v, input int n, input bit hp);
        ncs = 1'b0;
        wt(4);
        for (int i = 0; i < n; i++) begin
            if (hp && i == 4) begin
                wt(2);
                nhold = 1'b0; // pause with clock low
                repeat (2) begin
                    wt(4);
                    din = ~din;
                    spi_clk = 1'b1;
                    wt(4);
                    spi_clk = 1'b0;
                end
                wt(4);
                nhold = 1'b1;
            end
            din = v[31-i];
            wt(4);
            spi_clk = 1'b1;
            sh = {sh[6:0], dout_oe_n ? ~dout : dout}; // released line reads inverted
            wt(4);
            spi_clk = 1'b0;
        end
        wt(4);
        if (v[31:24] == 8'h05 || v[31:24] == 8'h03)
            got = sh;
        ncs = 1'b1;
        din = ~din;
        wt(8);
    endtask : frame
endmodule : secfe_master

// ### testbench/tb.sv
// self-checking bench of the command front end
`timescale 1ns/1ps
module tb;
    logic sys_clk, nrst, spi_clk, ncs, din, nhold, nwp, nv_restore, write_done, wl, bf, lk, ph, pl;
    logic [2:0] nv_bits, b;
    logic [7:0] rd_data, d;
    logic [10:0] a;
    logic hl, wv, sl, pa, dout, dout_oe_n;
    logic [7:0] wb, mg, g = 8'h00;
    logic [10:0] wa;
    logic [18:0] w = 19'h0, wc = 19'h0;
    logic [34:0] q[$];
    logic [34:0] e;
    logic p;
    int failures = 0;
    int total_checks = 0;
    event ev;
    secfe_master m (.sys_clk, .spi_clk, .ncs, .din, .nhold, .dout, .dout_oe_n, .got(mg));
    secfe_core DUT (.sys_clk, .nrst, .spi_clk, .ncs, .din, .nhold, .nwp, .dout, .dout_oe_n,
        .nv_restore, .nv_bits, .status_commit(), .status_new(), .wr_byte_valid(wv), .wr_byte(wb),
        .wr_byte_addr(wa), .wr_commit(), .write_done, .rd_addr(), .rd_req(), .rd_data,
        .write_latch_flag(wl), .busy_flag(bf), .status_lock_bit(lk), .protect_size_hi(ph),
        .protect_size_lo(pl), .hardware_lock_mode(hl), .selected(sl), .paused(pa));
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    task automatic give_verdict;
        if (failures == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    task automatic note(input logic [4:0] x);
        repeat (8) @(negedge sys_clk);
        q.push_back({x, x[2] & ~nwp, 2'b00, g, w});
        ->ev;
    endtask : note
    task automatic done_pulse;
        @(negedge sys_clk) write_done = 1'b1;
        @(negedge sys_clk) write_done = 1'b0;
    endtask : done_pulse
    always @(ev) begin
        e = q.pop_front();
        total_checks++;
        if ({wl, bf, lk, ph, pl, hl, sl, pa, mg, wc} !== e) begin
            failures++;
            $display("[FAIL] %0t status view %b, expected %b", $time,
                {wl, bf, lk, ph, pl, hl, sl, pa, mg, wc}, e);
        end
    end
    always @(negedge sys_clk)
        if (wv) wc = {wa, wb};
    initial begin
        #300000;
        failures++;
        give_verdict();
    end
    initial begin
        nrst = 1'b0;
        nwp = 1'b1;
        nv_restore = 1'b1;
        nv_bits = 3'h0;
        write_done = 1'b0;
        b = 3'h0;
        void'($urandom(32'h37967632));
        rd_data = 8'($urandom);
        repeat (2) @(negedge sys_clk);
        nrst = 1'b1;
        nv_restore = 1'b0;
        note({2'b00, b});
        for (int k = 0; k < 4; k++) begin
            d = 8'($urandom);
            d[7] = (k == 3);
            d[3:2] = 2'(k);
            m.frame(32'h06000000, 8, k == 0);
            note({2'b10, b});
            m.frame({8'h01, d, 16'h0}, 15, 0);
            note({2'b10, b});
            m.frame({8'h01, d, 16'h0}, 16, 0);
            m.frame(32'h05000000, 16, 0);
            g = {b[2], 3'h0, b[1:0], 2'b11};
            note({2'b11, b});
            done_pulse();
            b = {d[7], d[3:2]};
            note({2'b00, b});
            m.frame(32'h06000000, 8, 0);
            a = 11'($urandom);
            p = (k == 3) || (k == 1 && a >= 11'h600) || (k == 2 && a >= 11'h400);
            m.frame({8'h02, 5'h0, a, d}, 32, 0);
            w = {a, d};
            m.frame({8'h03, 5'h0, a, 8'h00}, 32, 0);
            g = rd_data;
            note({1'b1, !p, b});
            if (!p)
                done_pulse();
            m.frame(32'h04000000, 8, 0);
            note({2'b00, b});
        end
        nrst = 1'b0;
        m.frame(32'h06000000, 8, 0);
        nrst = 1'b1;
        note({2'b00, b});
        m.frame(32'h06000000, 9, 0);
        note({2'b00, b});
        m.frame(32'h09060000, 16, 0);
        note({2'b00, b});
        nwp = 1'b0;
        m.frame(32'h06000000, 8, 0);
        m.frame(32'h01000000, 16, 0);
        m.frame(32'h05000000, 16, 0);
        g = {b[2], 3'h0, b[1:0], 2'b10};
        note({2'b10, b});
        give_verdict();
    end
endmodule : tb
